// ### design/dcdp_pkg.sv
// package: constants for the dual codec digital path
package dcdp_pkg;
	// register byte offsets, one register per channel plus status
	localparam logic [3:0] DCDP_OFF_CTRL0 = 4'h0;
	localparam logic [3:0] DCDP_OFF_CTRL1 = 4'h4;
	localparam logic [3:0] DCDP_OFF_STAT = 4'h8;
	// control field positions
	localparam int DCDP_F_RATE_LO = 0;
	localparam int DCDP_F_MODE_LO = 2;
	localparam int DCDP_F_PWDN = 4;
	localparam logic [4:0] DCDP_CTRL_RST = 5'h00;
	// sample rate choices
	localparam logic [1:0] DCDP_RATE_48K = 2'h0;
	localparam logic [1:0] DCDP_RATE_44K1 = 2'h1;
	localparam logic [1:0] DCDP_RATE_8K = 2'h2;
	localparam logic [1:0] DCDP_RATE_16K = 2'h3;
	// loop mode choices
	localparam logic [1:0] DCDP_MODE_NORMAL = 2'h0;
	localparam logic [1:0] DCDP_MODE_DIGLOOP = 2'h1;
	localparam logic [1:0] DCDP_MODE_PARLOOP = 2'h2;
	// modulator oversampling ratio and clock
	localparam int DCDP_OSR = 64;
	localparam int DCDP_CLK_HZ = 100_000_000;
	localparam int DCDP_FS_48K_HZ = 48000;
	localparam int DCDP_FS_44K1_HZ = 44100;
	localparam int DCDP_FS_8K_HZ = 8000;
	localparam int DCDP_FS_16K_HZ = 16000;
	// divider reloads for the modulator bit rate (fs * osr), rounded down
	localparam logic [15:0] DCDP_DIV_48K = 16'(DCDP_CLK_HZ / (DCDP_FS_48K_HZ * DCDP_OSR));
	localparam logic [15:0] DCDP_DIV_44K1 = 16'(DCDP_CLK_HZ / (DCDP_FS_44K1_HZ * DCDP_OSR));
	localparam logic [15:0] DCDP_DIV_8K = 16'(DCDP_CLK_HZ / (DCDP_FS_8K_HZ * DCDP_OSR));
	localparam logic [15:0] DCDP_DIV_16K = 16'(DCDP_CLK_HZ / (DCDP_FS_16K_HZ * DCDP_OSR));
	localparam int DCDP_RECON_TAPS = 32;
	// loop mode enum
	typedef enum logic [1:0] {DCDP_NORMAL, DCDP_DIGLOOP, DCDP_PARLOOP} dcdp_mode_t;
endpackage : dcdp_pkg

// ### design/dcdp_top.sv
// dual codec digital path: decimation, interpolation, modulator, reconstruction
// ===========================================================================
// operating notes
// bus: every access takes two cycles; waitrequest is high in the first
//   and low in the second, where a write lands and read data stands
// bus: the read mux is loaded in the wait cycle, so the data seen at the
//   answering edge belongs to the address that was held
// bus: unmapped addresses read zero and ignore writes
// control word per channel: rate in bits 1:0, mode in 3:2, power-down in 4
// mode code 3 is refused and stored as normal, so only one loop is ever on
// status word: bits 0 and 2 flag a dsp write lost to parallel loop,
//   bits 1 and 3 one lost to power-down; sticky until reset
// frame timing: the bit divider gives one enable per modulator bit and
//   64 of them make one sample frame
// limitation: the divider rounds down, so each rate runs slightly fast;
//   an exact fractional divider was not worth its area here
// a rate change takes effect at the next divider reload, never mid-bit
// the converter bitstreams are asynchronous and pass three flip-flops;
//   a level is taken only once the last two agree, which rejects a
//   single metastable sample at the cost of two cycles of delay
// input side: cic decimator, one sample and one valid pulse per frame
// output side: word held, linear interpolator, second-order modulator
// reconstruction: 32 equal taps, output scaled count of ones
// digital loop swaps the two bitstreams and returns the held word
// parallel loop feeds the decimated word to the interpolator and drops
//   dsp writes, which only raise a status flag
// power-down freezes the divider of that channel alone, so no enables,
//   no valid pulses and no held-word updates happen there
// hazard: a write strobe in the cycle of a mode change follows the old
//   mode for holding and flagging; software should quiesce first
// reset: every register clears asynchronously; normal mode, 48 kHz rate
//   and both channels running follow release
// all outputs are registered except waitrequest
// ===========================================================================
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
module dcdp_top import dcdp_pkg::*; #(
	parameter int SW = 16,
	parameter int CIC_W = 36
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// avalon-mm slave
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// converter bitstreams, one bit per channel (from analog modulators, async)
	input wire logic [1:0] i_adc_pdm,
	// reconstruction filter output towards the analog driver
	output logic [SW-1:0] o_dac_recon0,
	output logic [SW-1:0] o_dac_recon1,
	// dsp sample port, channel 0
	output logic [SW-1:0] o_input_sample_word0,
	output logic o_input_valid0,
	input wire logic [SW-1:0] i_output_sample_word0,
	input wire logic i_output_write0,
	// dsp sample port, channel 1
	output logic [SW-1:0] o_input_sample_word1,
	output logic o_input_valid1,
	input wire logic [SW-1:0] i_output_sample_word1,
	input wire logic i_output_write1
);
	// =====================================================================
	// register bus
	logic [4:0] ctrl_q [2];
	logic ack_q;
	logic bus_req;
	logic [SW-1:0] in_word [2];
	logic in_valid [2];
	logic [SW-1:0] out_word [2];
	logic [1:0] out_wr;
	logic [SW-1:0] recon [2];
	logic [3:0] ovf_q;
	// bus handshake: request is combinational so the master sees the wait
	// state in the very cycle it asks; ack_q marks the answering cycle and
	// clears itself, so a held request cannot be answered twice in a row

	assign bus_req = i_avs_read | i_avs_write;
	// one wait cycle, then ack; simple and fixed latency
	assign o_avs_waitrequest = bus_req & ~ack_q;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= bus_req & ~ack_q;
		end
	end

	// control writes; illegal mode code 3 is folded to normal to keep modes exclusive
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_q[0] <= DCDP_CTRL_RST;
			ctrl_q[1] <= DCDP_CTRL_RST;
		end else if (i_avs_write && ack_q) begin
			for (int c = 0; c < 2; c++) begin
				if (i_avs_address == (c == 0 ? DCDP_OFF_CTRL0 : DCDP_OFF_CTRL1)) begin
					ctrl_q[c] <= i_avs_writedata[4:0];
					if (i_avs_writedata[DCDP_F_MODE_LO+1 -: 2] == 2'h3) begin
						ctrl_q[c][DCDP_F_MODE_LO+1 -: 2] <= DCDP_MODE_NORMAL;
					end
				end
			end
		end
	end

	// read data mux; unmapped reads return zero
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_avs_readdata <= 32'h0;
		end else if (i_avs_read && !ack_q) begin
			case (i_avs_address)
				DCDP_OFF_CTRL0: o_avs_readdata <= {27'h0, ctrl_q[0]};
				DCDP_OFF_CTRL1: o_avs_readdata <= {27'h0, ctrl_q[1]};
				DCDP_OFF_STAT: o_avs_readdata <= {28'h0, ovf_q};
				default: o_avs_readdata <= 32'h0;
			endcase
		end
	end

	assign out_word[0] = i_output_sample_word0;
	assign out_word[1] = i_output_sample_word1;
	assign out_wr = {i_output_write1, i_output_write0};

	// =====================================================================
	// rate decoding
	// divider reload for the chosen rate; kept in one place so the rate
	// table cannot drift between channels
	function automatic logic [15:0] rate_div(input logic [1:0] r);
		case (r)
			DCDP_RATE_48K: return DCDP_DIV_48K - 16'h1;
			DCDP_RATE_44K1: return DCDP_DIV_44K1 - 16'h1;
			DCDP_RATE_8K: return DCDP_DIV_8K - 16'h1;
			default: return DCDP_DIV_16K - 16'h1;
		endcase
	endfunction : rate_div

	// =====================================================================
	// per channel datapath
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		logic [1:0] rate;
		dcdp_mode_t mode;
		logic pwdn;
		logic [2:0] pdm_sync_q;
		logic adc_bit_q;
		logic [15:0] div_q;
		logic bit_en;
		logic [5:0] osr_q;
		logic fs_en;
		logic [CIC_W-1:0] i1_q, i2_q, i3_q, c1_q, c2_q, d1_q;
		logic [CIC_W-1:0] x0, x1, x2, x3;
		logic [SW-1:0] dec_q;
		logic [SW-1:0] hold_q;
		logic [SW-1:0] tx_q;
		logic [SW-1:0] interp_q;
		logic signed [SW+1:0] step_q;
		logic signed [SW+3:0] sd1_q, sd2_q;
		logic mod_bit;
		logic dec_in;
		logic rec_in;
		logic [DCDP_RECON_TAPS-1:0] sh_q;
		logic [SW-1:0] recon_q;
		logic [1:0] ovf_q_ch;

		assign rate = ctrl_q[ch][DCDP_F_RATE_LO+1 -: 2];
		assign mode = dcdp_mode_t'(ctrl_q[ch][DCDP_F_MODE_LO+1 -: 2]);
		assign pwdn = ctrl_q[ch][DCDP_F_PWDN];

		// three-stage sync of the async converter bit; change accepted on agreement
		always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				pdm_sync_q <= 3'h0;
				adc_bit_q <= 1'b0;
			end else begin
				pdm_sync_q <= {pdm_sync_q[1:0], i_adc_pdm[ch]};
				if (pdm_sync_q[1] == pdm_sync_q[2]) begin
					adc_bit_q <= pdm_sync_q[2];
				end
			end
		end

		// the reload is picked at each wrap, so a rate write never cuts a
		// bit short; power-down parks the counter at zero for a clean start
		// bit-rate divider and oversampling counter; frozen in power-down
		always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				div_q <= 16'h0;
				osr_q <= 6'h0;
			end else if (pwdn) begin
				div_q <= 16'h0;
				osr_q <= 6'h0;
			end else if (div_q == 16'h0) begin
				div_q <= rate_div(rate);
				osr_q <= osr_q + 6'h1;
			end else begin
				div_q <= div_q - 16'h1;
			end
		end
		assign bit_en = !pwdn && div_q == 16'h0;
		assign fs_en = bit_en && osr_q == 6'(DCDP_OSR - 1);

		// decimator input: converter bits, or own modulator bits in digital loop
		assign dec_in = (mode == DCDP_DIGLOOP) ? mod_bit : adc_bit_q;
		// reconstruction input: modulator, or converter bits in digital loop
		assign rec_in = (mode == DCDP_DIGLOOP) ? adc_bit_q : mod_bit;

		// integrators run at the bit rate and combs at the frame rate;
		// wrap-around in the integrators is harmless because the combs
		// subtract it out, provided CIC_W covers the full gain
		// x0 maps the bit to +1 or -1 so a silent input sits at mid-scale
		// third-order cic low-pass decimator, osr 64, 1-bit input mapped to +/-1
		assign x0 = dec_in ? CIC_W'(1) : {CIC_W{1'b1}};
		assign x1 = i3_q - d1_q;
		assign x2 = x1 - c1_q;
		assign x3 = x2 - c2_q;
		always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				{i1_q, i2_q, i3_q, c1_q, c2_q, d1_q} <= '0;
				dec_q <= '0;
			end else if (bit_en) begin
				i1_q <= i1_q + x0;
				i2_q <= i2_q + i1_q;
				i3_q <= i3_q + i2_q;
				if (fs_en) begin
					d1_q <= i3_q;
					c1_q <= x1;
					c2_q <= x2;
					// gain 64^3 = 2^18; keep top 16 of the 19-bit result
					dec_q <= x3[18:3];
				end
			end
		end

		// valid rises with the new word and lasts one cycle, so the dsp may
		// take the word at any point up to the next frame
		// dsp-visible input word: decimated, or written word in digital loop
		always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				in_word[ch] <= '0;
				in_valid[ch] <= 1'b0;
			end else begin
				in_valid[ch] <= fs_en;
				if (fs_en) begin
					in_word[ch] <= (mode == DCDP_DIGLOOP) ? hold_q : dec_q;
				end
			end
		end

		// a write in power-down is dropped as well, since that channel has
		// no frame to carry it
		// dsp writes held; discarded during parallel loop or power-down
		always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				hold_q <= '0;
			end else if (out_wr[ch] && !pwdn && mode != DCDP_PARLOOP) begin
				hold_q <= out_word[ch];
			end
		end

		// serialised word per frame, then linear interpolation in 64 steps
		always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				tx_q <= '0;
				interp_q <= '0;
				step_q <= '0;
			end else if (fs_en) begin
				tx_q <= (mode == DCDP_PARLOOP) ? dec_q : hold_q;
				interp_q <= tx_q;
				step_q <= ($signed({{2{tx_q[SW-1]}}, tx_q})
					- $signed({{2{interp_q[SW-1]}}, interp_q})) >>> 6;
			end else if (bit_en) begin
				interp_q <= SW'(interp_q + SW'(step_q));
			end
		end

		// the feedback level is one count below full scale, so a full-scale
		// negative interpolated word lowers sd1_q on every bit and runs away
		// hazard: sd2_q sign sets the output bit, so both integrators must
		// be wide enough for the worst case sum of two steps
		// second-order digital delta-sigma modulator, 1-bit out
		assign mod_bit = ~sd2_q[SW+3];
		always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				sd1_q <= '0;
				sd2_q <= '0;
			end else if (bit_en) begin
				sd1_q <= sd1_q + $signed({{4{interp_q[SW-1]}}, interp_q})
					- (mod_bit ? (SW+4)'(32767) : -(SW+4)'(32767));
				sd2_q <= sd2_q + sd1_q
					- (mod_bit ? (SW+4)'(32767) : -(SW+4)'(32767));
			end
		end

		// 32-tap boxcar reconstruction fir: output is scaled count of ones
		// limitation: flat taps trade stopband depth for zero multipliers
		always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				sh_q <= '0;
				recon_q <= '0;
			end else if (bit_en) begin
				sh_q <= {sh_q[DCDP_RECON_TAPS-2:0], rec_in};
				recon_q <= SW'({$countones({sh_q[DCDP_RECON_TAPS-2:0], rec_in}), 10'h0});
			end
		end
		assign recon[ch] = recon_q;

		// flags are set only; with no clear path there is no set/clear
		// collision to resolve, and software learns of any lost word
		// sticky: a dsp write arriving while powered down or looped in parallel
		always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				ovf_q_ch <= 2'h0;
			end else begin
				if (out_wr[ch] && mode == DCDP_PARLOOP) ovf_q_ch[0] <= 1'b1;
				if (out_wr[ch] && pwdn) ovf_q_ch[1] <= 1'b1;
			end
		end
		assign ovf_q[2*ch +: 2] = ovf_q_ch;
	end

	assign o_input_sample_word0 = in_word[0];
	assign o_input_sample_word1 = in_word[1];
	assign o_input_valid0 = in_valid[0];
	assign o_input_valid1 = in_valid[1];
	assign o_dac_recon0 = recon[0];
	assign o_dac_recon1 = recon[1];
endmodule : dcdp_top

// ### testbench/dcdp_chk_asserts.sv
// port checker for the dual codec digital path
`timescale 1ns/1ps
module dcdp_chk import dcdp_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic [15:0] o_dac_recon0,
	input wire logic o_input_valid0,
	input wire logic o_input_valid1
);
	// ==========
	// helpers
	logic pd0_q;
	wire req_w = i_avs_read || i_avs_write;
	wire rd_w = i_avs_read && !o_avs_waitrequest;
	// power-down of channel 0 as last written over the bus
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pd0_q <= 1'b0;
		end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == DCDP_OFF_CTRL0) begin
			pd0_q <= i_avs_writedata[DCDP_F_PWDN];
		end
	end
	// ==========
	// assertions
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	one_wait_a: assert property (req_w && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("bus answer late");
	idle_ready_a: assert property (!req_w |-> !o_avs_waitrequest)
		else $error("waitrequest while idle");
	unmapped_zero_a: assert property (rd_w && !(i_avs_address inside {4'h0, 4'h4, 4'h8})
		|-> o_avs_readdata == 32'h0) else $error("unmapped read not zero");
	ctrl_width_a: assert property (rd_w && i_avs_address < 4'h8 |-> o_avs_readdata[31:5] == 27'h0)
		else $error("control upper bits set");
	mode_legal_a: assert property (rd_w && i_avs_address < 4'h8 |-> o_avs_readdata[3:2] != 2'h3)
		else $error("illegal loop mode held");
	valid_pulse_a: assert property (o_input_valid0 |=> !o_input_valid0 [*8])
		else $error("channel 0 valid not a pulse");
	valid1_pulse_a: assert property ($rose(o_input_valid1) |=> $fell(o_input_valid1))
		else $error("channel 1 valid not a pulse");
	recon_scale_a: assert property (o_dac_recon0[9:0] == 10'h0 && o_dac_recon0 <= 16'h8000)
		else $error("reconstruction out of range");
	pdown_quiet_a: assert property (pd0_q && $past(pd0_q, 3) |-> !o_input_valid0)
		else $error("powered-down channel still samples");
	cover property (i_avs_write && !o_avs_waitrequest);
	cover property (o_input_valid0 && !pd0_q);
	cover property (pd0_q && o_input_valid1);
endmodule : dcdp_chk

// ### testbench/dcdp_dsp_model.sv
// dsp core model: answers each input frame with one output write
`timescale 1ns/1ps
module dcdp_dsp_model (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_valid,
	input wire logic [15:0] i_next,
	output logic [15:0] o_word,
	output logic o_write
);
	// word only means something under the strobe, so it churns otherwise
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_write <= 1'b0;
			o_word <= 16'h0;
		end else begin
			o_write <= i_valid;
			o_word <= i_valid ? i_next : ~o_word;
		end
	end
endmodule : dcdp_dsp_model

// ### testbench/tb.sv
// self-checking bench for the dual codec digital path
`timescale 1ns/1ps
module tb import dcdp_pkg::*;;
	logic i_sys_clk, i_rst_n, i_avs_read, i_avs_write, o_avs_waitrequest;
	logic [3:0] i_avs_address;
	logic [31:0] i_avs_writedata, o_avs_readdata, rdat, seed;
	logic [1:0] i_adc_pdm;
	logic [15:0] o_dac_recon0, o_dac_recon1, o_input_sample_word0, o_input_sample_word1;
	logic [15:0] i_output_sample_word0, i_output_sample_word1, nx0, nx1;
	logic o_input_valid0, o_input_valid1, i_output_write0, i_output_write1;
	int bad_count, check_count, n;
	// ==========
	// design, dsp models, clock and converter noise
	dcdp_top u_dut (.*);
	dcdp_dsp_model u_dsp0 (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_valid(o_input_valid0),
		.i_next(nx0), .o_word(i_output_sample_word0), .o_write(i_output_write0));
	dcdp_dsp_model u_dsp1 (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_valid(o_input_valid1),
		.i_next(nx1), .o_word(i_output_sample_word1), .o_write(i_output_write1));
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	// one generator only, so the bitstream and sample words never race
	always @(posedge i_sys_clk) begin
		seed <= xs(seed);
		i_adc_pdm <= seed[1:0];
	end
	// ==========
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge i_sys_clk);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_write <= w;
		i_avs_read <= !w;
		// sampled just after each edge: the values the design saw there
		do begin
			@(posedge i_sys_clk);
			k++;
		end while (o_avs_waitrequest !== 1'b0 && k < 50);
		chk(k < 50, 1);
		if (k >= 50) begin
			bad_count++;
			summarize();
		end
		rdat = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
	endtask : bus
	task automatic wait_v(input bit ch, input int lim, input bit quiet = 1'b0);
		n = 0;
		do begin
			@(negedge i_sys_clk);
			n++;
		end while ((ch ? o_input_valid1 : o_input_valid0) !== 1'b1 && n < lim);
		if (n >= lim && !quiet) begin
			bad_count++;
			summarize();
		end
	endtask : wait_v
	function automatic logic [31:0] divr(input int r);
		return r == 0 ? DCDP_DIV_48K : r == 1 ? DCDP_DIV_44K1 : r == 2 ? DCDP_DIV_8K : DCDP_DIV_16K;
	endfunction : divr
	task automatic summarize;
		if (bad_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize
	// ==========
	// scenarios
	initial begin
		{i_rst_n, i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} = '0;
		{nx0, nx1} = '0;
		seed = 32'h9445;
		repeat (12) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		bus(1, 4'hc, 32'hffff_ffff);
		// everything reads zero: normal mode, no stray alias of the unmapped write
		for (int a = 0; a < 16; a += 4) begin
			bus(0, a[3:0], 32'h0);
			chk(rdat, 32'h0);
		end
		// every rate on channel 1, written with the refused mode code
		for (int r = 0; r < 4; r++) begin
			bus(1, DCDP_OFF_CTRL1, 32'hc | r);
			bus(0, DCDP_OFF_CTRL1, 32'h0);
			chk(rdat, r);
			wait_v(1, 20000);
			wait_v(1, 20000);
			chk(n / DCDP_OSR, divr(r));
		end
		// digital loop: each written word comes back one frame later
		bus(1, DCDP_OFF_CTRL0, 32'h4);
		for (int i = 0; i < 3; i++) begin
			nx0 <= seed[15:0];
			wait_v(0, 5000);
			wait_v(0, 5000);
			chk(o_input_sample_word0, nx0);
		end
		// parallel loop: reads go on, writes are dropped and flagged
		bus(1, DCDP_OFF_CTRL1, 32'h8);
		wait_v(1, 5000);
		wait_v(1, 5000);
		chk(n < 5000, 1);
		bus(0, DCDP_OFF_STAT, 32'h0);
		chk(rdat, 32'h4);
		chk(o_dac_recon1 <= 16'h8000 && o_dac_recon1[9:0] == 10'h0, 1);
		// power down channel 0 alone; skip a frame pulse launched at the write edge
		bus(1, DCDP_OFF_CTRL0, 32'h10);
		repeat (2) @(posedge i_sys_clk);
		wait_v(0, 6000, 1'b1);
		chk(n, 6000);
		wait_v(1, 5000);
		chk(n < 5000, 1);
		summarize();
	end
	initial begin
		repeat (95000) @(posedge i_sys_clk);
		bad_count++;
		summarize();
	end
endmodule : tb
bind dcdp_top dcdp_chk u_chk (.*);
